// *** src/pll_ctrl_pkg.sv ***
// package: constants and types for the integer synthesizer control block
`default_nettype none
package pll_ctrl_pkg;
    // ------------------------------------------------------------
    // divider ranges
    // ------------------------------------------------------------
    localparam logic [7:0] m_min = 8'h04;
    localparam logic [7:0] m_max = 8'ha0;
    localparam logic [6:0] n_min = 7'h01;
    localparam logic [6:0] n_max = 7'h6e;
    localparam logic [8:0] c_min = 9'h001;
    localparam logic [8:0] c_max = 9'h1fe;
    // ------------------------------------------------------------
    // variant output counts, phase step
    // ------------------------------------------------------------
    localparam int bank_outputs = 7;
    localparam int fabric_outputs = 3;
    localparam logic [2:0] phase_steps = 3'h7;
    // ------------------------------------------------------------
    // register map (word addresses)
    // ------------------------------------------------------------
    localparam logic [3:0] addr_ctrl = 4'h0;
    localparam logic [3:0] addr_mult = 4'h1;
    localparam logic [3:0] addr_pre = 4'h2;
    localparam logic [3:0] addr_status = 4'h3;
    localparam logic [3:0] addr_cnt_base = 4'h8;
    localparam logic [31:0] ctrl_reset_value = 32'h0000_0010;
    localparam logic [7:0] mult_reset_value = 8'h04;
    localparam logic [6:0] pre_reset_value = 7'h01;
    localparam logic [8:0] cnt_reset_value = 9'h001;
    // ctrl fields
    localparam int ctrl_mode_lsb = 0;
    localparam int ctrl_bw_lsb = 3;
    localparam int ctrl_self_reset_bit = 5;
    localparam int ctrl_soft_reset_bit = 6;
    // ------------------------------------------------------------
    // lock timing
    // ------------------------------------------------------------
    localparam int lock_time_us = 10;
    localparam int clk_mhz = 20;
    localparam int lock_cycles = lock_time_us * clk_mhz;
    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        mode_direct = 3'b000,
        mode_diff_serial = 3'b001,
        mode_source_sync = 3'b010,
        mode_normal = 3'b011,
        zero_delay_buffer_mode = 3'b100,
        external_feedback_mode = 3'b101
    } fb_mode_t;
    typedef enum logic [1:0] {
        bw_low = 2'b00,
        bw_medium = 2'b01,
        bw_high = 2'b10
    } bandwidth_t;
    typedef enum logic [1:0] {
        st_reset = 2'b00,
        st_acquire = 2'b01,
        st_locked = 2'b10
    } lock_state_t;
    typedef struct packed {
        logic [3:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } bus_req_t;
endpackage
`default_nettype wire

// *** src/integer_pll_control_and_lock.sv ***
// module: digital control and lock tracking of an integer clock synthesizer
//
// Added by the designer: the placing of the registers and the plain strobed port.
`default_nettype none
module integer_pll_control_and_lock #(
    parameter bit bank_variant = 1'b1,
    parameter int lock_count = pll_ctrl_pkg::lock_cycles
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic pll_reset,
    input wire logic ref_present,
    input wire logic fb_phase_match,
    input wire logic [3:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    output logic locked,
    output logic counters_clear,
    output logic vco_nominal,
    output logic compensate,
    output logic dedicated_fb,
    output logic dynamic_phase_align_clock_en
);
    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic rst_s1_reg;
    logic rst_s2_reg;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rst_s1_reg <= 1'b0;
            rst_s2_reg <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_s2_reg <= rst_s1_reg;
        end
    end
    wire logic arst_n = rst_s2_reg;

    // range check shared by all dividers
    function automatic logic in_range(input logic [8:0] v, input logic [8:0] lo, input logic [8:0] hi);
        in_range = (v >= lo) && (v <= hi);
    endfunction

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    localparam int n_out = bank_variant ? pll_ctrl_pkg::bank_outputs : pll_ctrl_pkg::fabric_outputs;
    logic [6:0] ctrl_reg;
    logic [7:0] mult_reg;
    logic [6:0] pre_reg;
    logic [8:0] cnt_reg [n_out];
    logic [2:0] phase_reg [n_out];
    logic [31:0] rdata_reg;
    pll_ctrl_pkg::bus_req_t req;
    assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

    // decode
    wire logic wr_ctrl = req.wr && (req.addr == pll_ctrl_pkg::addr_ctrl);
    wire logic wr_mult = req.wr && (req.addr == pll_ctrl_pkg::addr_mult);
    wire logic wr_pre = req.wr && (req.addr == pll_ctrl_pkg::addr_pre);
    wire logic cnt_sel = req.addr[3];
    wire logic [2:0] cnt_idx = req.addr[2:0];
    wire logic cnt_hit = cnt_sel && (32'(cnt_idx) < n_out);

    // mode and bandwidth legality
    wire logic [2:0] mode_raw = ctrl_reg[2:0];
    wire logic [1:0] bw_raw = ctrl_reg[4:3];
    wire logic mode_ok = (mode_raw <= 3'h5) && (bank_variant || mode_raw != 3'h1);
    wire logic bw_ok = (bw_raw <= 2'h2) && (bank_variant || bw_raw != 2'h0);
    pll_ctrl_pkg::fb_mode_t mode;
    assign mode = mode_ok ? pll_ctrl_pkg::fb_mode_t'(mode_raw) : pll_ctrl_pkg::mode_direct;
    wire logic self_reset_en = ctrl_reg[pll_ctrl_pkg::ctrl_self_reset_bit];
    wire logic soft_reset = ctrl_reg[pll_ctrl_pkg::ctrl_soft_reset_bit];

    // divider legality over every output counter
    logic cnt_all_ok;
    always_comb begin
        cnt_all_ok = 1'b1;
        for (int i = 0; i < n_out; i++) begin
            if (!in_range(cnt_reg[i], pll_ctrl_pkg::c_min, pll_ctrl_pkg::c_max)) begin
                cnt_all_ok = 1'b0;
            end
        end
    end
    wire logic cfg_ok = in_range({1'b0, mult_reg}, {1'b0, pll_ctrl_pkg::m_min}, {1'b0, pll_ctrl_pkg::m_max})
        && in_range({2'b0, pre_reg}, {2'b0, pll_ctrl_pkg::n_min}, {2'b0, pll_ctrl_pkg::n_max})
        && cnt_all_ok && bw_ok;

    // control writes
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_reg <= pll_ctrl_pkg::ctrl_reset_value[6:0];
            mult_reg <= pll_ctrl_pkg::mult_reset_value;
            pre_reg <= pll_ctrl_pkg::pre_reset_value;
        end else begin
            if (wr_ctrl) ctrl_reg <= req.wdata[6:0];
            if (wr_mult) mult_reg <= req.wdata[7:0];
            if (wr_pre) pre_reg <= req.wdata[6:0];
        end
    end

    // output counter and phase writes: divide in [8:0], eighth-period phase step in [18:16]
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < n_out; i++) begin
                cnt_reg[i] <= pll_ctrl_pkg::cnt_reset_value;
                phase_reg[i] <= 3'h0;
            end
        end else if (req.wr && cnt_hit) begin
            cnt_reg[cnt_idx] <= req.wdata[8:0];
            phase_reg[cnt_idx] <= req.wdata[18:16];
        end
    end

    // ------------------------------------------------------------
    // lock state machine
    // ------------------------------------------------------------
    pll_ctrl_pkg::lock_state_t state_reg;
    pll_ctrl_pkg::lock_state_t state_next;
    logic [15:0] cnt_lock_reg;
    logic loss_reg;
    wire logic any_reset = pll_reset || soft_reset;
    wire logic matching = ref_present && fb_phase_match && cfg_ok;
    wire logic lock_done = cnt_lock_reg >= 16'(lock_count - 1);

    // next state
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            pll_ctrl_pkg::st_reset: state_next = pll_ctrl_pkg::st_acquire;
            pll_ctrl_pkg::st_acquire: if (matching && lock_done) state_next = pll_ctrl_pkg::st_locked;
            pll_ctrl_pkg::st_locked: if (!matching) state_next = self_reset_en ? pll_ctrl_pkg::st_reset
                                                     : pll_ctrl_pkg::st_acquire;
            default: state_next = pll_ctrl_pkg::st_reset;
        endcase
        if (any_reset) state_next = pll_ctrl_pkg::st_reset;
    end

    // state, lock count and sticky loss flag (set wins over read clear)
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= pll_ctrl_pkg::st_reset;
            cnt_lock_reg <= 16'h0000;
            loss_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_lock_reg <= (state_reg == pll_ctrl_pkg::st_acquire && matching) ? cnt_lock_reg + 16'h0001 : 16'h0000;
            if (state_reg == pll_ctrl_pkg::st_locked && state_next != pll_ctrl_pkg::st_locked) begin
                loss_reg <= 1'b1;
            end else if (req.rd && req.addr == pll_ctrl_pkg::addr_status) begin
                loss_reg <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // outputs, all registered
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            locked <= 1'b0;
            counters_clear <= 1'b1;
            vco_nominal <= 1'b1;
            compensate <= 1'b0;
            dedicated_fb <= 1'b0;
            dynamic_phase_align_clock_en <= 1'b0;
        end else begin
            locked <= (state_next == pll_ctrl_pkg::st_locked);
            counters_clear <= (state_next == pll_ctrl_pkg::st_reset);
            vco_nominal <= (state_next == pll_ctrl_pkg::st_reset);
            compensate <= (mode != pll_ctrl_pkg::mode_direct);
            dedicated_fb <= (mode == pll_ctrl_pkg::mode_normal || mode == pll_ctrl_pkg::mode_source_sync)
                && !ctrl_reg[pll_ctrl_pkg::ctrl_self_reset_bit];
            dynamic_phase_align_clock_en <= bank_variant && !any_reset;
        end
    end

    // ------------------------------------------------------------
    // read data, unmapped reads zero
    // ------------------------------------------------------------
    wire logic [31:0] cnt_word = cnt_hit ? {13'h0, phase_reg[cnt_idx], 7'h0, cnt_reg[cnt_idx]} : 32'h0;
    wire logic [31:0] status_word = {26'h0, n_out == pll_ctrl_pkg::bank_outputs, cfg_ok, loss_reg,
                                     state_reg == pll_ctrl_pkg::st_locked, state_reg};
    wire logic [31:0] rd_mux =
        (req.addr == pll_ctrl_pkg::addr_ctrl) ? {25'h0, ctrl_reg} :
        (req.addr == pll_ctrl_pkg::addr_mult) ? {24'h0, mult_reg} :
        (req.addr == pll_ctrl_pkg::addr_pre) ? {25'h0, pre_reg} :
        (req.addr == pll_ctrl_pkg::addr_status) ? status_word : cnt_word;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) rdata_reg <= 32'h0;
        else rdata_reg <= req.rd ? rd_mux : 32'h0;
    end
    assign rdata = rdata_reg;
endmodule
`default_nettype wire

// *** sim/integer_pll_control_and_lock_sva.sv ***
// assertion checker for the synthesizer control block
`default_nettype none
module integer_pll_control_and_lock_sva #(
    parameter bit bank_variant = 1'b1,
    parameter int lock_count = pll_ctrl_pkg::lock_cycles
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic pll_reset,
    input wire logic ref_present,
    input wire logic fb_phase_match,
    input wire logic [3:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [31:0] rdata,
    input wire logic locked,
    input wire logic counters_clear,
    input wire logic vco_nominal,
    input wire logic compensate,
    input wire logic dedicated_fb,
    input wire logic dynamic_phase_align_clock_en
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // lock stays low while the loop settles
    sequence s_dark;
        !locked [*3];
    endsequence
    property p_reset_drop;
        pll_reset |=> !locked;
    endproperty
    a_reset_drop: assert property (p_reset_drop) else $error("lock held through reset");
    property p_reset_clear;
        pll_reset |-> ##[1:2] counters_clear;
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("counters not cleared");
    property p_clear_state;
        counters_clear |-> vco_nominal && !locked;
    endproperty
    a_clear_state: assert property (p_clear_state) else $error("reset state outputs wrong");
    property p_lock_cause;
        $rose(locked) |-> $past(fb_phase_match) && $past(fb_phase_match, 2) && $past(ref_present);
    endproperty
    a_lock_cause: assert property (p_lock_cause) else $error("lock without match");
    property p_loss_drop;
        locked && !fb_phase_match |-> ##[1:3] !locked;
    endproperty
    a_loss_drop: assert property (p_loss_drop) else $error("lock kept after mismatch");
    property p_relock_delay;
        $fell(counters_clear) |-> s_dark;
    endproperty
    a_relock_delay: assert property (p_relock_delay) else $error("lock too soon");
    property p_dpa_bank;
        !counters_clear |-> dynamic_phase_align_clock_en == bank_variant;
    endproperty
    a_dpa_bank: assert property (p_dpa_bank) else $error("align clock on fabric variant");
    property p_rdata_idle;
        !rd |=> rdata == 32'h0;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside slot");
endmodule
bind integer_pll_control_and_lock integer_pll_control_and_lock_sva #(.bank_variant(bank_variant),
    .lock_count(lock_count)) u_sva (.clk(clk), .rstn(rstn), .pll_reset(pll_reset),
    .ref_present(ref_present), .fb_phase_match(fb_phase_match), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .locked(locked), .counters_clear(counters_clear), .vco_nominal(vco_nominal),
    .compensate(compensate), .dedicated_fb(dedicated_fb),
    .dynamic_phase_align_clock_en(dynamic_phase_align_clock_en));
`default_nettype wire

// *** sim/core_ctrl_model.sv ***
// core-side model: drives synthesizer reset, gates downstream logic
`default_nettype none
module core_ctrl_model (
    input wire logic clk,
    input wire logic locked,
    input wire logic auto_en,
    input wire logic req,
    output logic pll_reset,
    output logic downstream_en
);
    timeunit 1ns;
    timeprecision 1ns;
    logic locked_q = 1'b0;
    logic [1:0] hold = 2'h0;
    // reset pulse on request or on lost lock
    always @(posedge clk) begin
        locked_q <= locked;
        if (req || (auto_en && locked_q && !locked)) begin
            hold <= 2'h3;
        end else if (hold != 2'h0) begin
            hold <= hold - 2'h1;
        end
    end
    assign pll_reset = (hold != 2'h0);
    // downstream idle while lock lost
    assign downstream_en = locked;
endmodule
`default_nettype wire

// *** sim/integer_pll_control_and_lock_test.sv ***
// self-checking bench for the synthesizer control block
`default_nettype none
module integer_pll_control_and_lock_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic ref_present = 1'b0;
    logic fb_match = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic auto_en = 1'b0;
    logic req = 1'b0;
    logic pll_reset, locked, clr, vco_nom, comp, ded_fb, dpa_en, down_en;
    logic [31:0] rdata;
    int err_count = 0;
    int checks = 0;
    localparam logic [3:0] st = pll_ctrl_pkg::addr_status;
    localparam logic [3:0] ra [3] = '{pll_ctrl_pkg::addr_mult, pll_ctrl_pkg::addr_pre, pll_ctrl_pkg::addr_cnt_base};
    localparam logic [31:0] lo [3] = '{32'h4, 32'h1, 32'h1};
    localparam logic [31:0] hi [3] = '{32'ha0, 32'h6e, 32'h1fe};
    always #25 clk = ~clk;
    integer_pll_control_and_lock #(.bank_variant(1'b1), .lock_count(4)) u_dut (.clk(clk), .rstn(rstn),
        .pll_reset(pll_reset), .ref_present(ref_present), .fb_phase_match(fb_match), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .locked(locked), .counters_clear(clr),
        .vco_nominal(vco_nom), .compensate(comp), .dedicated_fb(ded_fb), .dynamic_phase_align_clock_en(dpa_en));
    core_ctrl_model u_core (.clk(clk), .locked(locked), .auto_en(auto_en), .req(req), .pll_reset(pll_reset),
        .downstream_en(down_en));
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop;
        if (err_count == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    // write, then status validity bit and readback
    task automatic try_cfg(input logic [3:0] a, input logic [31:0] d, input logic ok);
        logic [31:0] v;
        wr_reg(a, d);
        rd_reg(st, v);
        check({31'h0, v[4]}, {31'h0, ok});
        if (ok) begin
            rd_reg(a, v);
            check(v, d);
        end
    endtask
    // bounded wait on lock (sel 0) or counter clear (sel 1)
    task automatic wait_sig(input bit sel, input logic lvl);
        for (int n = 0; n < 40 && (sel ? clr : locked) !== lvl; n++) begin
            @(posedge clk);
            #1;
        end
        check({31'h0, sel ? clr : locked}, {31'h0, lvl});
    endtask
    // main sequence
    initial begin
        logic [31:0] v;
        repeat (16) @(posedge clk);
        check({28'h0, dpa_en, locked, clr, vco_nom}, 32'h3);
        rstn <= 1'b1;
        ref_present <= 1'b1;
        repeat (2) @(posedge clk);
        rd_reg(pll_ctrl_pkg::addr_ctrl, v);
        check(v, pll_ctrl_pkg::ctrl_reset_value);
        rd_reg(pll_ctrl_pkg::addr_cnt_base + 4'h6, v);
        check(v, {23'h0, pll_ctrl_pkg::cnt_reset_value});
        rd_reg(4'hf, v);
        check(v, 32'h0);
        rd_reg(st, v);
        check({31'h0, v[5]}, 32'h1);
        check({31'h0, dpa_en}, 32'h1);
        for (int k = 0; k < 3; k++) begin
            try_cfg(ra[k], lo[k] - 32'h1, 1'b0);
            try_cfg(ra[k], hi[k] + 32'h1, 1'b0);
            try_cfg(ra[k], hi[k], 1'b1);
            try_cfg(ra[k], lo[k], 1'b1);
        end
        try_cfg(pll_ctrl_pkg::addr_cnt_base + 4'h1, 32'h0007_0001, 1'b1);
        for (int b = 0; b < 4; b++) begin
            try_cfg(pll_ctrl_pkg::addr_ctrl, 32'(b) << 3, b != 3);
        end
        for (int m = 0; m < 7; m++) begin
            wr_reg(pll_ctrl_pkg::addr_ctrl, 32'h10 | 32'(m));
            rd_reg(pll_ctrl_pkg::addr_ctrl, v);
            check(v, 32'h10 | 32'(m));
            check({30'h0, comp, ded_fb}, {30'h0, m > 0 && m < 6, m == 2 || m == 3});
        end
        check({31'h0, locked}, 32'h0);
        fb_match <= 1'b1;
        wait_sig(1'b0, 1'b1);
        check({31'h0, down_en}, 32'h1);
        req <= 1'b1;
        @(posedge clk);
        req <= 1'b0;
        wait_sig(1'b1, 1'b1);
        check({31'h0, locked}, 32'h0);
        wait_sig(1'b0, 1'b1);
        fb_match <= 1'b0;
        wait_sig(1'b0, 1'b0);
        rd_reg(st, v);
        check({31'h0, v[3]}, 32'h1);
        rd_reg(st, v);
        check({31'h0, v[3]}, 32'h0);
        fb_match <= 1'b1;
        wait_sig(1'b0, 1'b1);
        wr_reg(pll_ctrl_pkg::addr_ctrl, 32'h30);
        fb_match <= 1'b0;
        wait_sig(1'b1, 1'b1);
        fb_match <= 1'b1;
        wr_reg(pll_ctrl_pkg::addr_ctrl, 32'h10);
        wait_sig(1'b0, 1'b1);
        wr_reg(pll_ctrl_pkg::addr_ctrl, 32'h50);
        wait_sig(1'b1, 1'b1);
        check({31'h0, dpa_en}, 32'h0);
        wr_reg(pll_ctrl_pkg::addr_ctrl, 32'h10);
        wait_sig(1'b0, 1'b1);
        auto_en <= 1'b1;
        fb_match <= 1'b0;
        wait_sig(1'b1, 1'b1);
        fb_match <= 1'b1;
        wait_sig(1'b0, 1'b1);
        report_and_stop();
    end
    // watchdog against a hang
    initial begin
        repeat (4000) @(posedge clk);
        err_count++;
        report_and_stop();
    end
endmodule
`default_nettype wire
